// ### core/pcs_ctrl.sv
// Purpose: Counter, gating, switchover, lock and scan control of a clock
//          synthesizer, modelled on the system clock
// Assumes: All inputs synchronous to clk; the oscillator is a numeric
//          phase accumulator ticking at most once per clk
// Notes:   Pre-scale and feedback values come from the scan chain
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_ctrl (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Reference and feedback inputs
  input  wire logic        ref_primary,
  input  wire logic        ref_secondary,
  input  wire logic        fb_in,
  input  wire logic        ext_fb_sel,
  // General control
  input  wire logic        pll_enable,
  input  wire logic        areset,
  input  wire logic        switch_req,
  input  wire logic        pfd_enable,
  // Output enables and pin mode
  input  wire logic [5:0]  clk_ena,
  input  wire logic [3:0]  ext_ena,
  input  wire logic        diff_mode,
  // Post-scale setup, divider 0..3 global, 4..5 regional, 6..9 external
  input  wire logic [99:0] post_div,
  input  wire logic [9:0]  post_half,
  input  wire logic [89:0] post_high,
  // Scan chain
  input  wire logic        scan_clk,
  input  wire logic        scan_data,
  input  wire logic        scan_clear,
  output logic             scan_out,
  // Clock outputs
  output logic [5:0]       clk_out,
  output logic [3:0]       ext_out_p,
  output logic [3:0]       ext_out_n,
  output logic             single_external_out,
  // Status
  output logic             clock_loss,
  output logic [1:0]       ref_bad,
  output logic             active_ref,
  output logic             locked
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  pcs_pkg::pcs_sel_e          sel;
  pcs_pkg::pcs_sel_e          next_sel;
  logic [1:0]                 ref_prev;
  logic [1:0]                 ref_rise;
  logic [15:0]                bad_cnt [2];
  logic                       sw_prev;
  logic                       sw_rise;
  logic                       auto_sw;
  logic                       run;
  logic                       sel_rise;
  logic [`PCS_SCAN_LEN-1:0]   chain;
  logic                       sclk_prev;
  logic                       sclk_rise;
  logic [`PCS_NM_W-1:0]       n_m1;
  logic [`PCS_NM_W-1:0]       m_m1;
  logic [`PCS_NM_W-1:0]       n_cnt;
  logic [`PCS_NM_W-1:0]       m_cnt;
  logic                       ref_pulse;
  logic [15:0]                acc;
  logic [16:0]                acc_sum;
  logic                       osc_tick;
  logic                       fb_prev;
  logic                       fb_pulse;
  logic [15:0]                step;
  logic [1:0]                 fb_seen;
  logic [3:0]                 lock_cnt;
  logic [`PCS_NUM_DIV-1:0]    ena_all;
  logic [`PCS_NUM_DIV-1:0]    raw_w;
  logic [`PCS_NUM_DIV-1:0]    out_q;

  // ----------------------------------------------------------------------
  // Reference edges, bad detection and selection
  // ----------------------------------------------------------------------
  assign run       = pll_enable & ~areset;
  assign ref_rise  = {ref_secondary, ref_primary} & ~ref_prev;
  assign sw_rise   = switch_req & ~sw_prev;
  assign auto_sw   = clock_loss & ~ref_bad[sel];
  assign sel_rise  = ref_rise[~sel];
  assign active_ref = (sel == pcs_pkg::PCS_REF_PRIMARY);
  assign clock_loss = ref_bad[~sel];

  // Edge history for references, request and scan clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ref_prev  <= 2'h0;
      sw_prev   <= 1'b0;
      sclk_prev <= 1'b0;
      fb_prev   <= 1'b0;
    end else begin
      ref_prev  <= {ref_secondary, ref_primary};
      sw_prev   <= switch_req;
      sclk_prev <= scan_clk;
      fb_prev   <= fb_in;
    end
  end

  // Per-reference silence counter; saturates at the timeout
  for (genvar r = 0; r < 2; r++) begin : g_bad
    always_ff @(posedge clk) begin
      if (!resetn || ref_rise[r])
        bad_cnt[r] <= 16'h0000;
      else if (bad_cnt[r] != 16'(`PCS_BAD_CYC))
        bad_cnt[r] <= bad_cnt[r] + 16'h0001;
    end
    assign ref_bad[r] = (bad_cnt[r] == 16'(`PCS_BAD_CYC));
  end

  // Manual request wins; automatic switch only toward a live reference
  always_comb begin
    next_sel = sel;
    unique case (sel)
      pcs_pkg::PCS_REF_PRIMARY: begin
        if (sw_rise || auto_sw)
          next_sel = pcs_pkg::PCS_REF_SECONDARY;
      end
      pcs_pkg::PCS_REF_SECONDARY: begin
        if (sw_rise || auto_sw)
          next_sel = pcs_pkg::PCS_REF_PRIMARY;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      sel <= pcs_pkg::PCS_REF_PRIMARY;
    else
      sel <= next_sel;
  end

  // ----------------------------------------------------------------------
  // Scan chain, holds feedback and pre-scale values minus one
  // ----------------------------------------------------------------------
  assign sclk_rise = scan_clk & ~sclk_prev;
  assign scan_out  = chain[`PCS_SCAN_LEN-1];
  assign m_m1 = chain[`PCS_SCAN_M_LSB +: `PCS_NM_W];
  assign n_m1 = chain[`PCS_SCAN_N_LSB +: `PCS_NM_W];

  // Clear beats a shift arriving in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn || scan_clear)
      chain <= '0;
    else if (sclk_rise)
      chain <= {chain[`PCS_SCAN_LEN-2:0], scan_data};
  end

  // ----------------------------------------------------------------------
  // Pre-scale, oscillator, feedback and detector
  // ----------------------------------------------------------------------
  assign ref_pulse = sel_rise & (n_cnt == n_m1);
  assign acc_sum   = {1'b0, acc} + {1'b0, step};
  assign fb_pulse  = ext_fb_sel ? (fb_in & ~fb_prev)
                                : (osc_tick & (m_cnt == m_m1));

  // Counters restart while stopped so outputs come back aligned
  always_ff @(posedge clk) begin
    if (!resetn || !run) begin
      n_cnt    <= '0;
      m_cnt    <= '0;
      acc      <= 16'h0000;
      osc_tick <= 1'b0;
    end else begin
      if (sel_rise)
        n_cnt <= ref_pulse ? '0 : n_cnt + 9'h001;
      if (osc_tick)
        m_cnt <= (m_cnt == m_m1) ? '0 : m_cnt + 9'h001;
      acc      <= acc_sum[15:0];
      osc_tick <= acc_sum[16];
    end
  end

  // Oscillator rate nudged by detector; step held when detector is off
  always_ff @(posedge clk) begin
    if (!resetn)
      step <= `PCS_STEP_RST;
    else if (pfd_enable && run) begin
      if (ref_pulse && !fb_pulse && step != `PCS_STEP_MAX)
        step <= step + 16'h0001;
      else if (fb_pulse && !ref_pulse && step != `PCS_STEP_MIN)
        step <= step - 16'h0001;
    end
  end

  // Lock: a run of reference periods each holding exactly one feedback
  always_ff @(posedge clk) begin
    if (!resetn || !run) begin
      fb_seen  <= 2'h0;
      lock_cnt <= 4'h0;
    end else if (ref_pulse) begin
      fb_seen  <= {1'b0, fb_pulse};
      if (fb_seen == 2'h1 && lock_cnt != `PCS_LOCK_CNT)
        lock_cnt <= lock_cnt + 4'h1;
      else if (fb_seen != 2'h1)
        lock_cnt <= 4'h0;
    end else if (fb_pulse && fb_seen != 2'h2) begin
      fb_seen  <= fb_seen + 2'h1;
    end
  end
  assign locked = (lock_cnt == `PCS_LOCK_CNT);

  // ----------------------------------------------------------------------
  // Post-scale dividers with glitch-free gating
  // ----------------------------------------------------------------------
  assign ena_all = {ext_ena, clk_ena};

  for (genvar g = 0; g < `PCS_NUM_DIV; g++) begin : g_post
    logic [`PCS_POST_W-1:0] cnt;
    logic [`PCS_POST_W-1:0] lim;
    logic [`PCS_POST_W:0]   thr;
    logic                   en_eff;
    logic                   en_nxt;
    logic                   raw_prev;
    logic [`PCS_POST_W-1:0] req;
    assign req = post_div[g*`PCS_POST_W +: `PCS_POST_W];
    // Non-half duty caps at 512 to keep the high count representable
    assign lim = (post_half[g] || req <= `PCS_NON50_MAX) ? req
               : `PCS_NON50_MAX;
    assign thr = post_half[g]
               ? ({1'b0, lim} + 11'h002) >> 1
               : {2'b00, post_high[g*`PCS_HIGH_W +: `PCS_HIGH_W]};
    assign raw_w[g] = ({1'b0, cnt} < thr);
    // A high phase under way keeps its gate; divide-by-one has no low phase
    assign en_nxt = (raw_w[g] && raw_prev && lim != '0) ? en_eff
                  : ena_all[g];

    // Gate decided as each high phase starts, so no pulse is ever cut
    always_ff @(posedge clk) begin
      if (!resetn || !run) begin
        cnt    <= '0;
        en_eff <= 1'b0;
        raw_prev <= 1'b0;
        out_q[g] <= 1'b0;
      end else begin
        if (osc_tick)
          cnt <= (cnt == lim) ? '0 : cnt + 10'h001;
        raw_prev <= raw_w[g];
        en_eff   <= en_nxt;
        out_q[g] <= raw_w[g] & en_nxt;
      end
    end
  end

  // Output mapping; n pin is complement only in pair mode
  assign clk_out   = out_q[5:0];
  assign ext_out_p = out_q[9:6];
  assign ext_out_n = diff_mode ? ~out_q[9:6] : out_q[9:6];
  assign single_external_out = out_q[0];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence manual_req_s;
    sw_rise ##1 1'b1;
  endsequence

  sequence dead_active_s;
    auto_sw && !sw_rise;
  endsequence

  switch_flip_a: assert property (@(posedge clk) disable iff (!resetn)
    sw_rise |=> active_ref != $past(active_ref))
    else $error("manual switchover did not change reference");

  auto_switch_a: assert property (@(posedge clk) disable iff (!resetn)
    dead_active_s |=> active_ref != $past(active_ref))
    else $error("dead reference not switched out");

  manual_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    manual_req_s ##0 !sw_rise && !auto_sw |=> $stable(active_ref))
    else $error("reference changed without cause");

  lock_reset_a: assert property (@(posedge clk) disable iff (!resetn)
    !run |=> !locked [*2])
    else $error("lock held through reset");

  gate_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !clk_ena[0] && !clk_out[0] |=> !clk_out[0])
    else $error("disabled clock output restarted");

  trunc_free_a: assert property (@(posedge clk) disable iff (!resetn)
    clk_out[1] && raw_w[1] && run |=> clk_out[1])
    else $error("clock pulse truncated");

  scan_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    scan_clear |=> chain == '0 && !scan_out)
    else $error("scan chain not cleared");

  scan_shift_a: assert property (@(posedge clk) disable iff (!resetn)
    sclk_rise && !scan_clear
      |=> chain[0] == $past(scan_data)
          && scan_out == $past(chain[`PCS_SCAN_LEN-2]))
    else $error("scan shift wrong");

  bad_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    ref_rise[0] |=> !ref_bad[0] [*2])
    else $error("toggling primary flagged bad");

  pfd_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !pfd_enable |=> step == $past(step))
    else $error("loop corrected with detector off");
endmodule

// ### core/pcs_defs.svh
// Purpose: Constants for the clock synthesizer counter and switch control
// Assumes: System clock of 40 MHz
// Notes:   Divider values are carried as value minus one
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCS_CLK_MHZ        40
`define PCS_BAD_TIMEOUT_NS 1000
`define PCS_BAD_CYC ((`PCS_BAD_TIMEOUT_NS*`PCS_CLK_MHZ+999)/1000)
`define PCS_LOCK_CNT       4'hf
// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define PCS_NM_W           9
`define PCS_POST_W         10
`define PCS_HIGH_W         9
`define PCS_NUM_INT        6
`define PCS_NUM_EXT        4
`define PCS_NUM_DIV        10
`define PCS_SCAN_LEN       18
`define PCS_NON50_MAX      10'h1ff
// ----------------------------------------------------------------------
// Scan chain fields, step reset value and step limits
// ----------------------------------------------------------------------
`define PCS_SCAN_M_LSB     0
`define PCS_SCAN_N_LSB     9
`define PCS_STEP_RST       16'h4000
`define PCS_STEP_MIN       16'h0001
`define PCS_STEP_MAX       16'hffff
`endif

// ### core/pcs_pkg.sv
// Purpose: Types for the clock synthesizer counter and switch control
// Assumes: Used with pcs_defs.svh
// Notes:   Select code matches the active reference output level
package pcs_pkg;
  typedef enum logic {
    PCS_REF_SECONDARY = 1'b0,
    PCS_REF_PRIMARY   = 1'b1
  } pcs_sel_e;
endpackage

// ### sim/pcs_partner.sv
// Purpose: Far side of the synthesizer: reference oscillators and the
//          board trace that loops an external clock pin back to feedback
// Assumes: References are modelled as toggles on the system clock
// Notes:   A stopped reference holds its level, as a dead oscillator does
`timescale 1ns/1ps
module pcs_partner #(
  parameter int HALF = 8
) (
  // Clock and run controls from the bench
  input  wire logic clk,
  input  wire logic run_p,
  input  wire logic run_s,
  // Board loop source
  input  wire logic loop_in,
  // Pins toward the synthesizer
  output logic      ref_primary,
  output logic      ref_secondary,
  output logic      fb_in
);
  int cnt;
  // ----------------------------------------------------------------------
  // Reference oscillators, both at the same rate
  // ----------------------------------------------------------------------
  initial begin
    cnt = 0;
    ref_primary = 1'b0;
    ref_secondary = 1'b0;
  end
  // Each reference toggles only while its run control is high
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      if (run_p) ref_primary <= #2 ~ref_primary;
      if (run_s) ref_secondary <= #2 ~ref_secondary;
    end
  end
  // Board trace from the first external pin
  assign fb_in = loop_in;
endmodule

// ### sim/pcs_ctrl_tb_top.sv
// Purpose: Self-checking bench for the synthesizer counter and switch control
// Assumes: Inputs change 2 ns after the rising clock edge
// Notes:   Loop lock is awaited under a bounded count, not a fixed delay
`timescale 1ns/1ps
module pcs_ctrl_tb_top;
  logic        clk, resetn, ref_primary, ref_secondary, fb_in, ext_fb_sel;
  logic        pll_enable, areset, switch_req, pfd_enable, diff_mode;
  logic [5:0]  clk_ena, clk_out;
  logic [3:0]  ext_ena, ext_out_p, ext_out_n;
  logic [99:0] post_div;
  logic [9:0]  post_half;
  logic [89:0] post_high;
  logic        scan_clk, scan_data, scan_clear, scan_out, single_external_out;
  logic        clock_loss, active_ref, locked, run_p, run_s, p0, p1, seen;
  logic [1:0]  ref_bad;
  int          err_count, tests_run, n0, n1, dmis, i;
  // ----------------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------------
  pcs_ctrl i_dut (.clk(clk), .resetn(resetn), .ref_primary(ref_primary),
    .ref_secondary(ref_secondary), .fb_in(fb_in), .ext_fb_sel(ext_fb_sel),
    .pll_enable(pll_enable), .areset(areset), .switch_req(switch_req),
    .pfd_enable(pfd_enable), .clk_ena(clk_ena), .ext_ena(ext_ena),
    .diff_mode(diff_mode), .post_div(post_div), .post_half(post_half),
    .post_high(post_high), .scan_clk(scan_clk), .scan_data(scan_data),
    .scan_clear(scan_clear), .scan_out(scan_out), .clk_out(clk_out),
    .ext_out_p(ext_out_p), .ext_out_n(ext_out_n),
    .single_external_out(single_external_out), .clock_loss(clock_loss),
    .ref_bad(ref_bad), .active_ref(active_ref), .locked(locked));
  pcs_partner i_far (.clk(clk), .run_p(run_p), .run_s(run_s),
    .loop_in(ext_out_p[0]), .ref_primary(ref_primary),
    .ref_secondary(ref_secondary), .fb_in(fb_in));
  // ----------------------------------------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Edge counts and per-cycle pin relations; a glitch would show up here
  always @(posedge clk) begin
    p0 <= clk_out[0];
    p1 <= clk_out[1];
    if (clk_out[0] === 1'b1 && p0 === 1'b0) n0++;
    if (clk_out[1] === 1'b1 && p1 === 1'b0) n1++;
    if (clock_loss === 1'b1) seen = 1'b1;
    if (single_external_out !== clk_out[0]) dmis++;
    if (diff_mode && ext_out_n !== ~ext_out_p) dmis++;
    if (!diff_mode && ext_out_n !== ext_out_p) dmis++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic check(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic shift(input logic b);
    scan_data = b;
    scan_clk = 1'b1;
    step(1);
    scan_clk = 1'b0;
    step(1);
  endtask
  task automatic toggle_ref(input logic exp);
    switch_req = 1'b1;
    step(1);
    switch_req = 1'b0;
    step(1);
    check("active_ref", {9'h0, exp}, {9'h0, active_ref});
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog sized well beyond the lock wait plus all scenarios
  initial begin
    #(60000 * 25);
    err_count++;
    conclude();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {resetn, ext_fb_sel, areset, switch_req, scan_clk, scan_data} = 6'h0;
    {scan_clear, run_p, run_s, pll_enable, pfd_enable, diff_mode} = 6'h1f;
    {clk_ena, ext_ena} = 10'h3ff;
    post_div = {30'h0, 10'h003, 40'h0, 10'h003, 10'h001};
    post_half = 10'h3ff;
    post_high = {10{9'h001}};
    {err_count, tests_run, n0, n1, dmis} = '0;
    seen = 1'b0;
    step(16);
    resetn = 1'b1;
    check("locked", 10'h0, {9'h0, locked});
    check("active_ref", 10'h1, {9'h0, active_ref});
    check("ref_bad", 10'h0, {8'h0, ref_bad});
    check("scan_out", 10'h0, {9'h0, scan_out});
    // One marker bit walks the whole chain to the last register
    shift(1'b1);
    for (i = 0; i < 16; i++) shift(1'b0);
    check("scan_out early", 10'h0, {9'h0, scan_out});
    shift(1'b0);
    check("scan_out last", 10'h1, {9'h0, scan_out});
    scan_clear = 1'b1;
    step(2);
    scan_clear = 1'b0;
    check("scan_out cleared", 10'h0, {9'h0, scan_out});
    // Pre-scale 1 and feedback 4 match the reference to the reset rate
    for (i = 0; i < 18; i++) shift(i >= 16);
    check("scan_out loaded", 10'h0, {9'h0, scan_out});
    toggle_ref(1'b0);
    toggle_ref(1'b1);
    // Bounded wait for the loop to settle
    for (i = 0; i < 20000 && locked !== 1'b1; i++) step(1);
    check("locked", 10'h1, {9'h0, locked});
    {n0, n1} = '0;
    step(1600);
    check("ratio 2 to 4", 10'h1, {9'h0, (n0 - 2 * n1) inside {[-2:2]}});
    check("edges", 10'h1, {9'h0, n1 > 4});
    check("pin pairs", 10'h0, dmis[9:0]);
    // Loop closed through the first external pin, pins in phase
    ext_fb_sel = 1'b1;
    diff_mode = 1'b0;
    step(40);
    for (i = 0; i < 2000 && locked !== 1'b1; i++) step(1);
    check("locked ext fb", 10'h1, {9'h0, locked});
    check("pin pairs single", 10'h0, dmis[9:0]);
    ext_fb_sel = 1'b0;
    diff_mode = 1'b1;
    // Drop all enables, let high phases finish, then outputs stay low
    clk_ena = 6'h0;
    ext_ena = 4'h0;
    pfd_enable = 1'b0;
    step(80);
    {n0, n1} = '0;
    for (i = 0; i < 100; i++) begin
      step(1);
      if (clk_out !== 6'h0 || ext_out_p !== 4'h0) n0++;
    end
    check("gated outputs", 10'h0, n0[9:0]);
    check("gated pins", 10'h0, {6'h0, ext_out_p});
    clk_ena = 6'h3f;
    ext_ena = 4'hf;
    pfd_enable = 1'b1;
    // Primary stops: flagged, clock loss seen, automatic move to secondary
    run_p = 1'b0;
    step(80);
    check("ref_bad", 10'h1, {8'h0, ref_bad});
    check("clock_loss seen", 10'h1, {9'h0, seen});
    check("active_ref", 10'h0, {9'h0, active_ref});
    run_p = 1'b1;
    step(40);
    check("ref_bad back", 10'h0, {8'h0, ref_bad});
    // Loop reset and disable both drop lock and quiet the outputs
    areset = 1'b1;
    step(3);
    check("locked", 10'h0, {9'h0, locked});
    check("clk_out", 10'h0, {4'h0, clk_out});
    areset = 1'b0;
    pll_enable = 1'b0;
    step(3);
    check("locked", 10'h0, {9'h0, locked});
    check("ext pins", 10'h0, {6'h0, ext_out_p});
    conclude();
  end
endmodule
